// ===== design/fcrl_pkg.sv
// constants, register map and helpers for the flash configuration register logic
package fcrl_pkg;
	// register byte offsets on the lite bus
	localparam logic [7:0] FCRL_OFF_CONFIG = 8'h00;
	localparam logic [7:0] FCRL_OFF_PROTECT = 8'h04;
	localparam logic [7:0] FCRL_OFF_COMMAND = 8'h08;
	localparam logic [7:0] FCRL_OFF_PROT_RANGE = 8'h0c;
	localparam logic [7:0] FCRL_OFF_PARAM_RANGE = 8'h10;
	// configuration_control field positions
	localparam int FCRL_BIT_LOCK = 0;
	localparam int FCRL_BIT_QUAD = 1;
	localparam int FCRL_BIT_PARAM_TOP = 2;
	localparam int FCRL_BIT_BP_VOLATILE = 3;
	localparam int FCRL_BIT_FROM_BOTTOM = 5;
	// command register bits
	localparam int FCRL_BIT_CMD_WREN = 0;
	localparam int FCRL_BIT_CMD_WRDIS = 1;
	// range register fields
	localparam int FCRL_BIT_PROT_NONE = 31;
	localparam int FCRL_BIT_PARAM_PRESENT = 24;
	// reset values
	localparam logic [7:0] FCRL_CONFIG_SHIP = 8'h00;
	localparam logic [2:0] FCRL_BP_SHIP = 3'h0;
	localparam logic [2:0] FCRL_BP_VOLATILE_RESET = 3'h7;
	// array geometry
	localparam logic [8:0] FCRL_SECTORS = 9'h100;
	localparam logic [23:0] FCRL_ARRAY_LAST = 24'hffffff;
	localparam logic [23:0] FCRL_PARAM_BYTES = 24'h020000;
	localparam int FCRL_PARAM_COUNT = 32;
	localparam logic [8:0] FCRL_BP_MIN_SECTORS = 9'h004;
	// bus responses
	localparam logic [1:0] FCRL_RESP_OKAY = 2'h0;
	localparam logic [1:0] FCRL_RESP_SLVERR = 2'h2;

	// protected 64 KB sectors for a block protect code
	function automatic logic [8:0] fcrl_prot_sectors(input logic [2:0] level);
		logic [8:0] cnt;
		cnt = 9'h000;
		if (level == 3'h7) begin
			cnt = FCRL_SECTORS;
		end else if (level != 3'h0) begin
			cnt = FCRL_BP_MIN_SECTORS << (level - 3'h1);
		end
		return cnt;
	endfunction : fcrl_prot_sectors
endpackage : fcrl_pkg

// ===== design/fcrl_axil_slave.sv
// lite bus slave handshake: one write and one read in flight
`timescale 1ns/1ps
module fcrl_axil_slave import fcrl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit
);
	logic rd_pend; // read address held, data next edge

	// write goes out once both halves are held and no response waits
	assign wr_en = !awready && !wready && !bvalid;

	// write address, data and response
	always_ff @(posedge clk) begin
		if (!rstn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= FCRL_RESP_OKAY;
			wr_addr <= 8'h00;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? FCRL_RESP_OKAY : FCRL_RESP_SLVERR;
				awready <= 1'b1;
				wready <= 1'b1;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read address and data
	always_ff @(posedge clk) begin
		if (!rstn) begin
			arready <= 1'b1;
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= FCRL_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rd_addr <= araddr;
			rd_pend <= 1'b1;
		end else if (rd_pend) begin
			rd_pend <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_hit ? rd_data : 32'h0;
			rresp <= rd_hit ? FCRL_RESP_OKAY : FCRL_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule : fcrl_axil_slave

// ===== design/fcrl_region_map.sv
// protected sector range and parameter region placement
`timescale 1ns/1ps
module fcrl_region_map import fcrl_pkg::*; #(
	parameter bit UNIFORM_256 = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// settings
	input wire logic [2:0] block_protect_level,
	input wire logic protect_from_bottom,
	input wire logic param_sector_at_top,
	// registered map
	output logic prot_none,
	output logic [7:0] prot_first,
	output logic [7:0] prot_last,
	output logic param_present,
	output logic [23:0] param_base
);
	wire [8:0] prot_cnt = fcrl_prot_sectors(block_protect_level); // 64 KB sectors covered
	wire [8:0] top_first = FCRL_SECTORS - prot_cnt; // first sector when grown from top
	wire [8:0] bot_last = prot_cnt - 9'h001; // last sector when grown from bottom

	// code 001 covers 1/64, each step doubles, 111 covers all
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prot_none <= 1'b1;
			prot_first <= 8'h00;
			prot_last <= 8'h00;
			param_present <= 1'b0;
			param_base <= 24'h0;
		end else begin
			prot_none <= (prot_cnt == 9'h000); // [RULE16]
			prot_first <= protect_from_bottom ? 8'h00 : top_first[7:0]; // [RULE13]
			prot_last <= protect_from_bottom ? bot_last[7:0] : 8'hff; // [RULE13]
			// small sectors sit at the chosen end; absent on the large uniform part
			param_present <= !UNIFORM_256; // [RULE10]
			param_base <= (param_sector_at_top && !UNIFORM_256) ?
				(FCRL_ARRAY_LAST - FCRL_PARAM_BYTES + 24'h1) : 24'h0; // [RULE7] [RULE8]
		end
	end
endmodule : fcrl_region_map

// ===== design/fcrl_config_top.sv
// configuration register bank of a serial flash, reached over a lite bus
`timescale 1ns/1ps
//
// Contract
// RULE1 - lock refuses protect, direction, placement changes
// RULE2 - lock once set clears only at power-on
// RULE3 - unlocked register accepts writes including lock
// RULE4 - quad bit remaps two pins to data lanes
// RULE5 - single and dual reads still work in quad
// RULE6 - quad disables write-protect and pause functions
// RULE7 - thirty-two 4 KB parameter sectors, rest 64 KB
// RULE8 - placement bit one puts parameters on top
// RULE9 - placement, volatility, direction bits are set-once
// RULE10 - large uniform variant lacks placement bit
// RULE11 - host fixes placement and direction before programming
// RULE12 - volatile protect bits load 111 at power-on
// RULE13 - direction bit zero grows protection from top
// RULE14 - host avoids parameters and protection same end
// RULE15 - unused bits zero, shipped all zero
// RULE16 - code 001 covers 1/64, doubling up
// RULE17 - write enable latch clears after register write
// RULE18 - refused bits kept, permitted bits still applied
module fcrl_config_top import fcrl_pkg::*; #(
	parameter bit UNIFORM_256 = 1'b0 // large uniform sector variant
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic rstn,
	// returns the non-volatile cells to shipment state
	input wire logic nv_init_n,
	// lite bus write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// lite bus read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// shared pins, sampled levels
	input wire logic write_protect_accel_pin_n,
	input wire logic pause_pin_n,
	// pin function select
	output logic data_lane_two,
	output logic data_lane_three,
	output logic write_protect_active,
	output logic pause_active,
	// permitted read kinds: single, dual output, dual io, quad
	output logic read_single_ok,
	output logic read_dual_out_ok,
	output logic read_dual_io_ok,
	output logic read_quad_ok,
	// protection map toward the array engine
	output logic prot_none,
	output logic [7:0] prot_first,
	output logic [7:0] prot_last,
	output logic [2:0] block_protect_level
);
	// register side of the bus slave
	logic wr_en; // one cycle write request
	logic [7:0] wr_addr; // byte address of the write
	logic [31:0] wr_data; // write data
	logic [3:0] wr_strb; // byte enables
	logic [7:0] rd_addr; // byte address of the read
	logic [31:0] rd_data; // selected read word

	// volatile state, reset by power-on
	logic lock; // freezes the protection setup
	logic write_enable_latch; // arms one register write
	logic [2:0] bp_volatile; // protect level when volatile

	// non-volatile cells, survive power-on reset
	logic quad_select; // pins act as data lanes
	logic param_sector_at_top; // parameter sectors at high addresses
	logic protect_bits_volatile; // protect level held in volatile copy
	logic protect_from_bottom; // protection grows from address zero
	logic [2:0] bp_nonvolatile; // protect level when non-volatile

	// map results
	logic param_present; // parameter region exists
	logic [23:0] param_base; // first byte of the parameter region

	// decode results for the slave, driven below
	logic wr_hit; // write address maps to a writable register
	logic rd_hit; // read address maps to any register

	// slave answers only from registers; a write lands one edge after
	// both halves are held, so the register side sees a one-cycle strobe
	fcrl_axil_slave fcrl_axil_slave_inst (
		.clk(clk),
		.rstn(rstn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// map outputs trail the live level by one more edge; the array
	// engine should not act on them in the edge a level changes
	fcrl_region_map #(
		.UNIFORM_256(UNIFORM_256)
	) fcrl_region_map_inst (
		.clk(clk),
		.rstn(rstn),
		.block_protect_level(block_protect_level),
		.protect_from_bottom(protect_from_bottom),
		.param_sector_at_top(param_sector_at_top),
		.prot_none(prot_none),
		.prot_first(prot_first),
		.prot_last(prot_last),
		.param_present(param_present),
		.param_base(param_base)
	);

	// address decode, separate for each direction
	wire wr_cfg = wr_addr == FCRL_OFF_CONFIG;
	wire wr_bp = wr_addr == FCRL_OFF_PROTECT;
	wire wr_cmd = wr_addr == FCRL_OFF_COMMAND;
	// range registers are read-only, a write there is an error
	assign wr_hit = wr_cfg || wr_bp || wr_cmd;
	wire rd_cfg = rd_addr == FCRL_OFF_CONFIG;
	wire rd_bp = rd_addr == FCRL_OFF_PROTECT;
	wire rd_cmd = rd_addr == FCRL_OFF_COMMAND;
	wire rd_prot = rd_addr == FCRL_OFF_PROT_RANGE;
	wire rd_param = rd_addr == FCRL_OFF_PARAM_RANGE;
	assign rd_hit = rd_cfg || rd_bp || rd_cmd || rd_prot || rd_param;

	// a config or protect write only lands on the low byte lane with the latch armed; a command write needs only the lane
	wire lane0 = wr_strb[0];
	wire cfg_go = wr_en && wr_cfg && lane0 && write_enable_latch;
	wire bp_go = wr_en && wr_bp && lane0 && write_enable_latch;
	wire cmd_go = wr_en && wr_cmd && lane0;
	// only the low byte carries register bits; upper bytes are ignored
	wire [7:0] wd = wr_data[7:0];

	// next values of the configuration bits
	// lock can only rise; nothing but power-on brings it back
	wire next_lock = lock | wd[FCRL_BIT_LOCK]; // [RULE2] [RULE3]
	// quad select is not frozen by the lock, it may go either way
	wire next_quad = wd[FCRL_BIT_QUAD]; // [RULE3]
	// the freeze looks at the lock as it stood before the write, so one
	// write may set the lock and the bits it guards together
	// one-way bits: an accepted write only ORs in ones
	wire next_param_top = (lock || UNIFORM_256) ? param_sector_at_top :
		(param_sector_at_top | wd[FCRL_BIT_PARAM_TOP]); // [RULE1] [RULE9] [RULE10]
	wire next_bp_volatile_sel = protect_bits_volatile | wd[FCRL_BIT_BP_VOLATILE]; // [RULE9]
	wire next_from_bottom = lock ? protect_from_bottom :
		(protect_from_bottom | wd[FCRL_BIT_FROM_BOTTOM]); // [RULE1] [RULE9]

	// a locked protect write is refused but still spends the latch
	// the host has to arm the latch again after a refused write
	wire bp_take = bp_go && !lock; // [RULE1] [RULE18]

	// the stored level is kept while the volatile copy is live; only
	// factory init brings it back, since that clears the select too
	// which copy of the protect level is live
	wire [2:0] bp_live = protect_bits_volatile ? bp_volatile : bp_nonvolatile; // [RULE12]

	// range words come from the registered map, two edges behind a protect write and one behind a config write
	// read word assembly; unused and do-not-use positions read zero
	wire [7:0] cfg_word = {2'b00, protect_from_bottom, 1'b0, protect_bits_volatile,
		param_sector_at_top, quad_select, lock}; // [RULE15]
	wire [31:0] prot_word = {prot_none, 15'h0, prot_first, prot_last};
	wire [31:0] param_word = {7'h0, param_present, param_base};
	assign rd_data = rd_cfg ? {24'h0, cfg_word} :
		rd_bp ? {29'h0, block_protect_level} :
		rd_cmd ? {31'h0, write_enable_latch} :
		rd_prot ? prot_word :
		rd_param ? param_word : 32'h0;

	// volatile bits: lock falls at power-on only
	// factory init alone leaves the lock as it is
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lock <= 1'b0; // [RULE2]
		end else if (cfg_go) begin
			lock <= next_lock; // [RULE2] [RULE3]
		end
	end

	// write enable latch: armed by command, spent by any register write
	// a command write never spends the latch itself
	always_ff @(posedge clk) begin
		if (!rstn) begin
			write_enable_latch <= 1'b0;
		end else if (cfg_go || bp_go) begin
			write_enable_latch <= 1'b0; // [RULE17]
		end else if (cmd_go && wd[FCRL_BIT_CMD_WRDIS]) begin
			// disable wins when both command bits are set
			write_enable_latch <= 1'b0;
		end else if (cmd_go && wd[FCRL_BIT_CMD_WREN]) begin
			write_enable_latch <= 1'b1;
		end
	end

	// volatile protect copy comes up fully protected
	// writes while non-volatile skip this copy, so a later switch to
	// volatile still starts from full protection
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bp_volatile <= FCRL_BP_VOLATILE_RESET; // [RULE12]
		end else if (bp_take && protect_bits_volatile) begin
			bp_volatile <= wd[2:0];
		end
	end

	// non-volatile cells ignore power-on; only the init input ships them
	// cells take a write at once; no program time is modelled
	always_ff @(posedge clk) begin
		if (!nv_init_n) begin
			quad_select <= FCRL_CONFIG_SHIP[FCRL_BIT_QUAD]; // [RULE15]
			param_sector_at_top <= FCRL_CONFIG_SHIP[FCRL_BIT_PARAM_TOP];
			protect_bits_volatile <= FCRL_CONFIG_SHIP[FCRL_BIT_BP_VOLATILE];
			protect_from_bottom <= FCRL_CONFIG_SHIP[FCRL_BIT_FROM_BOTTOM];
		end else if (cfg_go) begin
			quad_select <= next_quad; // [RULE4]
			param_sector_at_top <= next_param_top; // [RULE8] [RULE18]
			protect_bits_volatile <= next_bp_volatile_sel; // [RULE9]
			protect_from_bottom <= next_from_bottom; // [RULE13] [RULE18]
		end
	end

	// non-volatile protect level, written only while not volatile
	always_ff @(posedge clk) begin
		if (!nv_init_n) begin
			bp_nonvolatile <= FCRL_BP_SHIP;
		end else if (bp_take && !protect_bits_volatile) begin
			bp_nonvolatile <= wd[2:0]; // [RULE12]
		end
	end

	// pin functions: quad turns the two shared pins into data lanes and
	// drops their protect and pause roles; registered so outputs are clean
	// the pins are taken as synchronous; there is no metastability guard
	always_ff @(posedge clk) begin
		if (!rstn) begin
			data_lane_two <= 1'b0;
			data_lane_three <= 1'b0;
			write_protect_active <= 1'b0;
			pause_active <= 1'b0;
		end else begin
			data_lane_two <= quad_select; // [RULE4]
			data_lane_three <= quad_select; // [RULE4]
			write_protect_active <= !quad_select && !write_protect_accel_pin_n; // [RULE6]
			pause_active <= !quad_select && !pause_pin_n; // [RULE6]
		end
	end

	// read kinds: the narrow reads never depend on the quad bit
	// quad reads wait for the quad bit so the lanes are never contended
	always_ff @(posedge clk) begin
		if (!rstn) begin
			read_single_ok <= 1'b0;
			read_dual_out_ok <= 1'b0;
			read_dual_io_ok <= 1'b0;
			read_quad_ok <= 1'b0;
		end else begin
			read_single_ok <= 1'b1; // [RULE5]
			read_dual_out_ok <= 1'b1; // [RULE5]
			read_dual_io_ok <= 1'b1; // [RULE5]
			read_quad_ok <= quad_select;
		end
	end

	// live protect level toward the array, one cycle behind the cells
	// reset shows full protection on this level, while the map resets to prot_none
	always_ff @(posedge clk) begin
		if (!rstn) begin
			block_protect_level <= FCRL_BP_VOLATILE_RESET;
		end else begin
			block_protect_level <= bp_live; // [RULE12]
		end
	end
endmodule : fcrl_config_top

// ===== sim/fcrl_config_props.sv
// assertions on the ports of the configuration register bank
`timescale 1ns/1ps
module fcrl_config_props import fcrl_pkg::*; (
	// clock and resets
	input wire logic clk,
	input wire logic rstn,
	input wire logic nv_init_n,
	// read channel
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// pins and pin functions
	input wire logic write_protect_accel_pin_n,
	input wire logic pause_pin_n,
	input wire logic data_lane_two,
	input wire logic data_lane_three,
	input wire logic write_protect_active,
	input wire logic pause_active,
	input wire logic read_single_ok,
	input wire logic read_dual_out_ok,
	input wire logic read_dual_io_ok,
	input wire logic read_quad_ok,
	// protection map
	input wire logic prot_none,
	input wire logic [7:0] prot_first,
	input wire logic [7:0] prot_last,
	input wire logic [2:0] block_protect_level
);
	logic [7:0] ar_q; // address of the read in flight
	logic [5:0] seen; // set-once and lock bits already read back as one
	logic [8:0] span; // protected sectors shown by the map
	logic [8:0] want; // sectors that the live code asks for
	assign span = 9'(prot_last) - 9'(prot_first) + 9'h001;
	assign want = (block_protect_level == 3'h7) ? 9'h100 : (9'h004 << (block_protect_level - 3'h1));
	// remember which read is answered
	always_ff @(posedge clk) begin
		if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
	end
	// power-on drops only the lock; factory init drops everything
	always_ff @(posedge clk) begin
		if (!nv_init_n) seen <= 6'h00;
		else if (!rstn) seen <= seen & 6'h2c;
		else if (s_axi_rvalid && ar_q == FCRL_OFF_CONFIG) seen <= seen | (s_axi_rdata[5:0] & 6'h2d);
	end
	AST_STICKY: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_rvalid && ar_q == FCRL_OFF_CONFIG |-> (s_axi_rdata[5:0] & seen) == seen)
		else $error("set-once bit returned to zero");
	AST_CFG_ZERO: assert property (@(posedge clk) disable iff (!rstn)
		s_axi_rvalid && ar_q == FCRL_OFF_CONFIG |-> s_axi_rdata[31:6] == 26'h0 && !s_axi_rdata[4])
		else $error("unused config bit reads one");
	AST_LANES: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |-> data_lane_three == data_lane_two && read_quad_ok == data_lane_two)
		else $error("lane selects disagree");
	AST_QUAD_OFF: assert property (@(posedge clk) disable iff (!rstn)
		data_lane_two |-> !write_protect_active && !pause_active)
		else $error("pin function active in quad mode");
	AST_WP_ON: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) && !data_lane_two |-> write_protect_active == !$past(write_protect_accel_pin_n))
		else $error("write protect does not follow its pin");
	AST_PAUSE_ON: assert property (@(posedge clk) disable iff (!rstn)
		!data_lane_two && !pause_pin_n ##1 !data_lane_two |-> pause_active)
		else $error("pause does not follow its pin");
	AST_READS: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) |-> read_single_ok && read_dual_out_ok && read_dual_io_ok)
		else $error("single or dual read refused");
	AST_PROT_SIZE: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn, 2) && $past(rstn) && $stable(block_protect_level)
		&& $past(block_protect_level) == $past(block_protect_level, 2)
		|-> prot_none == (block_protect_level == 3'h0) && (prot_none || span == want))
		else $error("protected size wrong for code");
	AST_PROT_END: assert property (@(posedge clk) disable iff (!rstn)
		!prot_none |-> prot_first == 8'h00 || prot_last == 8'hff)
		else $error("protected range not at an array end");
endmodule : fcrl_config_props

bind fcrl_config_top fcrl_config_props fcrl_config_props_inst (.clk(clk), .rstn(rstn),
	.nv_init_n(nv_init_n), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.write_protect_accel_pin_n(write_protect_accel_pin_n), .pause_pin_n(pause_pin_n),
	.data_lane_two(data_lane_two), .data_lane_three(data_lane_three),
	.write_protect_active(write_protect_active), .pause_active(pause_active),
	.read_single_ok(read_single_ok), .read_dual_out_ok(read_dual_out_ok),
	.read_dual_io_ok(read_dual_io_ok), .read_quad_ok(read_quad_ok), .prot_none(prot_none),
	.prot_first(prot_first), .prot_last(prot_last), .block_protect_level(block_protect_level));

// ===== sim/fcrl_pin_host.sv
// host model driving the shared write-protect and pause pins
`timescale 1ns/1ps
module fcrl_pin_host (
	// clock
	input wire logic clk,
	// what the host wants
	input wire logic quad_mode,
	input wire logic wp_low,
	input wire logic pause_low,
	// shared pins
	output logic write_protect_accel_pin_n,
	output logic pause_pin_n
);
	logic [1:0] lane_pat = 2'h1; // data on the pins while they are lanes
	// as lanes the pins carry changing data, never a steady level
	always @(posedge clk) begin
		lane_pat <= lane_pat + 2'h1;
		write_protect_accel_pin_n <= quad_mode ? lane_pat[0] : !wp_low;
		pause_pin_n <= quad_mode ? lane_pat[1] : !pause_low;
	end
endmodule : fcrl_pin_host

// ===== sim/fcrl_config_top_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %0t: got %h want %h", $time, g, e); end end
module fcrl_config_top_tb import fcrl_pkg::*; ;
	localparam logic [1:0] OK = FCRL_RESP_OKAY, ER = FCRL_RESP_SLVERR;
	localparam logic [7:0] CFG = FCRL_OFF_CONFIG, PRT = FCRL_OFF_PROTECT, CMD = FCRL_OFF_COMMAND;
	localparam logic [7:0] RNG = FCRL_OFF_PROT_RANGE, PAR = FCRL_OFF_PARAM_RANGE;
	// bus drive, all idle at time zero
	logic clk = 1'b0, rstn = 1'b0, nv_init_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wp_low = 1'b0, pause_low = 1'b0, quad = 1'b0; // host wishes
	// design answers
	logic awready, wready, bvalid, arready, rvalid, wp_n, pause_n;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic lane2, lane3, wp_act, pause_act, rd_s, rd_do, rd_dio, rd_q, pnone;
	logic [7:0] pfirst, plast;
	logic [2:0] bpl;
	int bad_count = 0, comparisons = 0, sp;
	logic [33:0] rq[$], e; // expected read answers
	logic [1:0] bq[$], eb; // expected write answers
	always #2.5 clk = ~clk;
	fcrl_config_top #(.UNIFORM_256(1'b0)) fcrl_config_top_inst (.clk(clk), .rstn(rstn),
		.nv_init_n(nv_init_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .write_protect_accel_pin_n(wp_n),
		.pause_pin_n(pause_n), .data_lane_two(lane2), .data_lane_three(lane3),
		.write_protect_active(wp_act), .pause_active(pause_act), .read_single_ok(rd_s),
		.read_dual_out_ok(rd_do), .read_dual_io_ok(rd_dio), .read_quad_ok(rd_q),
		.prot_none(pnone), .prot_first(pfirst), .prot_last(plast), .block_protect_level(bpl));
	fcrl_pin_host fcrl_pin_host_inst (.clk(clk), .quad_mode(quad), .wp_low(wp_low),
		.pause_low(pause_low), .write_protect_accel_pin_n(wp_n), .pause_pin_n(pause_n));
	// answers are compared against the oldest note as they appear
	always @(posedge clk) begin
		if (rvalid && rready) begin
			e = rq.pop_front();
			`CHK({rresp, rdata}, e)
		end
		if (bvalid && bready) begin
			eb = bq.pop_front();
			`CHK(bresp, eb)
		end
	end
	// upper bytes are random; only byte lane 0 matters
	function automatic logic [31:0] rv(input logic [7:0] b);
		logic [31:0] u;
		u = $urandom();
		return {u[31:8], b};
	endfunction : rv
	// one write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = OK,
		input logic [3:0] s = 4'h1);
		int n;
		bq.push_back(r);
		@(posedge clk);
		awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 40);
		bready <= 1'b0;
		if (n >= 40) bad_count++;
	endtask : wr
	// one read, expected answer noted first
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = OK);
		int n;
		rq.push_back({r, d});
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 40);
		rready <= 1'b0;
		if (n >= 40) bad_count++;
	endtask : rd
	// arm the write enable latch, then write
	task automatic cw(input logic [7:0] a, input logic [31:0] d);
		wr(CMD, rv(8'h01));
		wr(a, d);
	endtask : cw
	// power-on reset, optionally back to factory state
	task automatic rst(input logic nv);
		rstn <= 1'b0; nv_init_n <= !nv;
		repeat (2) @(posedge clk);
		rstn <= 1'b1; nv_init_n <= 1'b1;
	endtask : rst
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	// the whole run needs a few hundred cycles; this is far beyond
	initial begin
		#100000;
		bad_count++;
		results();
	end
	initial begin
		void'($urandom(32'h8eabc65b));
		rst(1'b1);
		rd(CFG, 32'h0);
		rd(8'h14, 32'h0, ER);
		wr(RNG, rv(8'h00), ER);
		$display("test ship done");
		wr(CMD, rv(8'h01));
		rd(CMD, 32'h1);
		wr(CFG, rv(8'h26), OK, 4'he);
		rd(CFG, 32'h0);
		cw(CFG, rv(8'h26));
		rd(CMD, 32'h0);
		rd(CFG, 32'h26);
		rd(PAR, 32'h01fe0000);
		quad <= 1'b1; wp_low <= 1'b1; pause_low <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK({lane2, lane3, wp_act, pause_act, rd_q}, 5'b11001)
		`CHK({rd_s, rd_do, rd_dio}, 3'b111)
		$display("test quad done");
		cw(CFG, rv(8'h00));
		rd(CFG, 32'h24);
		quad <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK({lane2, wp_act, pause_act}, 3'b011)
		$display("test set-once done");
		for (int i = 1; i < 8; i++) begin
			sp = (i == 7) ? 256 : 4 << (i - 1);
			cw(PRT, rv(8'(i)));
			rd(PRT, 32'(i));
			rd(RNG, {24'h0, 8'(sp - 1)});
		end
		$display("test levels done");
		cw(CFG, rv(8'h25));
		rd(CFG, 32'h25);
		cw(PRT, rv(8'h02));
		rd(PRT, 32'h7);
		cw(CFG, rv(8'hda));
		rd(CFG, 32'h2f);
		rd(PRT, 32'h7);
		rst(1'b0);
		rd(CFG, 32'h2e);
		rd(PRT, 32'h7);
		cw(PRT, rv(8'h02));
		rd(PRT, 32'h2);
		$display("test lock done");
		rst(1'b1);
		cw(PRT, rv(8'h01));
		rd(RNG, 32'h0000fcff);
		`CHK({pnone, pfirst, plast, bpl}, {1'b0, 8'hfc, 8'hff, 3'h1})
		rd(PAR, 32'h01000000);
		$display("test top done");
		results();
	end
endmodule : fcrl_config_top_tb
